// File: pkg/fpfs_pkg.sv
// Purpose: constants for the floppy pin and function select block
// Assumes: one clock, synchronous active-high reset
// Notes: field positions of the pin-select and floppy option configuration
// Functional notes
// - printer data bit 7 drives ext drive A select open drain in two-drive mode only.
// - density select bit 0 goes out on its own open-drain pin.
// - two-bit field picks density-1 pin: density, gpio1 bit0, kbc line 12, sci.
// - gpio1 bit0 on density pin also feeds alternate interrupt input 1.
// - head select high means side 0, low means side 1.
// - write data active low open drain; write enable open drain too.
// - one active-low step pulse per head movement to another track.
// - step direction high outward, low inward.
// - motor on b pulled low enables drive 1, released otherwise.
// - motor on a pulled low enables drive 0, released otherwise.
// - drive select a and b pulled low enable their drives.
// - read data enters through a pulled-up input.
// - option bit 7 set turns off the five input pull-ups.
// - cfg a bit 6 picks gate a20 output or gpio1 bit1 with irq 2.
// - cfg a bit 7 picks kbd reset or gpio1 bit2 with watchdog output.
// - cfg b bit 0 picks kbd inhibit input or gpio1 bit3.
package fpfs_pkg;
  localparam int        DEN1_SEL_LSB  = 0;
  localparam int        ADDR_LINE20_GATE_SEL_BIT  = 6;
  localparam int        KBD_RESET_OUT_SEL_BIT = 7;
  localparam int        KINH_SEL_BIT  = 0;
  localparam int        PU_OFF_BIT    = 7;
  localparam logic [1:0] DEN1_DENSITY = 2'h0;
  localparam logic [1:0] DEN1_GPIO    = 2'h1;
  localparam logic [1:0] DEN1_KBC     = 2'h2;
  localparam logic [1:0] DEN1_SCI     = 2'h3;
  localparam logic [7:0] CFG_A_RST    = 8'h00;
  localparam logic [7:0] CFG_B_RST    = 8'h00;
  localparam logic [7:0] FOPT_RST     = 8'h00;
endpackage : fpfs_pkg

// File: core/fpfs_pins.sv
// Purpose: pad-level pin muxing for floppy and shared function pins
// Assumes: internal cores are on clk; drive inputs are asynchronous
// Notes: open-drain pins expose out/oe; out is 0 when driven on dedicated pins, shared pins can drive 1
`timescale 1ns/100ps
`default_nettype none
module fpfs_pins (
  input  wire logic       clk,
  input  wire logic       srst,
  // configuration
  input  wire logic [7:0] pin_select_cfg_a,
  input  wire logic [7:0] pin_select_cfg_b,
  input  wire logic [7:0] floppy_option_cfg,
  input  wire logic       ext_two_drive_mode,
  // floppy controller side, active low as on the pins
  input  wire logic       fdc_ext_drive_a_select_n,
  input  wire logic       fdc_density_sel_0,
  input  wire logic       fdc_density_sel_1,
  input  wire logic       fdc_head_side0,
  input  wire logic       fdc_write_en_n,
  input  wire logic       fdc_write_data_n,
  input  wire logic       fdc_step_n,
  input  wire logic       fdc_dir_out,
  input  wire logic       fdc_motor_on_a_n,
  input  wire logic       fdc_motor_on_b_n,
  input  wire logic       fdc_drive_select_a_n,
  input  wire logic       fdc_drive_select_b_n,
  // other cores
  input  wire logic       gpio1_out,
  input  wire logic [3:0] gpio1_oe,
  input  wire logic [3:0] gpio1_dout,
  input  wire logic       kbc_port_line_twelve_out,
  input  wire logic       kbc_port_line_twelve_oe,
  input  wire logic       system_ctl_irq_n,
  input  wire logic       addr_line20_gate,
  input  wire logic       kbd_reset_out,
  input  wire logic       wdog_timeout_out,
  input  wire logic       wdog_on_gpio12,
  // core-side inputs
  output logic [3:0]      gpio1_din,
  output logic            alt_irq_input_1,
  output logic            alt_irq_input_2,
  output logic            kbc_port_line_twelve_in,
  output logic            kbd_inhibit_in,
  output logic            media_changed,
  output logic            read_data,
  output logic            write_protected,
  output logic            track_zero,
  output logic            index_mark,
  output logic            input_pullup_off,
  // pads
  input  wire logic       printer_data_bit7_in,
  output logic            printer_data_bit7_out,
  output logic            printer_data_bit7_oe,
  output logic            density_sel_0_oe,
  input  wire logic       density_sel_1_in,
  output logic            density_sel_1_out,
  output logic            density_sel_1_oe,
  output logic            head_oe,
  output logic            write_en_oe,
  output logic            write_serial_out_oe,
  output logic            step_oe,
  output logic            dir_oe,
  output logic            motor_on_b_oe,
  output logic            motor_on_a_oe,
  output logic            drive_select_a_oe,
  output logic            drive_select_b_oe,
  input  wire logic       media_changed_in,
  input  wire logic       read_data_in,
  input  wire logic       write_protect_in,
  input  wire logic       track_zero_in,
  input  wire logic       index_in,
  input  wire logic       a20_pin_in,
  output logic            a20_pin_out,
  output logic            a20_pin_oe,
  input  wire logic       kbd_reset_out_pin_in,
  output logic            kbd_reset_out_pin_out,
  output logic            kbd_reset_out_pin_oe,
  input  wire logic       kinh_pin_in,
  output logic            kinh_pin_out,
  output logic            kinh_pin_oe,
  output logic            head_out,
  output logic            od_low
);
  logic [1:0] den1_sel;
  logic       addr_line20_gate_gpio;
  logic       kbd_reset_out_gpio;
  logic       kinh_gpio;
  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  logic [7:0] pin_raw;
  logic [7:0] out_ff;
  logic [7:0] nxt_out;
  logic [10:0] oe_ff;
  logic [10:0] nxt_oe;
  logic [3:0] mux_out_ff;
  logic [3:0] mux_oe_ff;
  logic [3:0] nxt_mux_out;
  logic [3:0] nxt_mux_oe;

  assign den1_sel   = pin_select_cfg_a[fpfs_pkg::DEN1_SEL_LSB +: 2];
  assign addr_line20_gate_gpio  = pin_select_cfg_a[fpfs_pkg::ADDR_LINE20_GATE_SEL_BIT];
  assign kbd_reset_out_gpio = pin_select_cfg_a[fpfs_pkg::KBD_RESET_OUT_SEL_BIT];
  assign kinh_gpio  = pin_select_cfg_b[fpfs_pkg::KINH_SEL_BIT];
  assign input_pullup_off = floppy_option_cfg[fpfs_pkg::PU_OFF_BIT];
  assign od_low = 1'b0;

  // input synchroniser: two flops before any logic
  assign pin_raw = {kinh_pin_in, kbd_reset_out_pin_in, a20_pin_in, density_sel_1_in,
                    index_in, track_zero_in, write_protect_in, read_data_in};
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_ff <= 8'hFF;
      s2_ff <= 8'hFF;
    end else begin
      s1_ff <= pin_raw;
      s2_ff <= s1_ff;
    end
  end

  logic mc1_ff;
  logic mc2_ff;
  always_ff @(posedge clk) begin
    if (srst) begin
      mc1_ff <= 1'b1;
      mc2_ff <= 1'b1;
    end else begin
      mc1_ff <= media_changed_in;
      mc2_ff <= mc1_ff;
    end
  end

  // drive status, active high inside
  assign media_changed   = ~mc2_ff;
  assign read_data       = ~s2_ff[0];
  assign write_protected = ~s2_ff[1];
  assign track_zero      = ~s2_ff[2];
  assign index_mark      = ~s2_ff[3];

  // shared pin inputs routed only to the selected function
  assign alt_irq_input_1 = (den1_sel == fpfs_pkg::DEN1_GPIO) & s2_ff[4];
  assign kbc_port_line_twelve_in = (den1_sel == fpfs_pkg::DEN1_KBC) ? s2_ff[4] : 1'b1;
  assign alt_irq_input_2 = addr_line20_gate_gpio & s2_ff[5];
  assign kbd_inhibit_in  = kinh_gpio ? 1'b1 : s2_ff[7];
  always_comb begin
    gpio1_din    = 4'h0;
    gpio1_din[0] = (den1_sel == fpfs_pkg::DEN1_GPIO) & s2_ff[4];
    gpio1_din[1] = addr_line20_gate_gpio & s2_ff[5];
    gpio1_din[2] = kbd_reset_out_gpio & s2_ff[6];
    gpio1_din[3] = kinh_gpio & s2_ff[7];
  end

  // dedicated open-drain outputs: enable pulls low
  always_comb begin
    nxt_oe     = 11'h000;
    nxt_oe[0]  = ext_two_drive_mode & ~fdc_ext_drive_a_select_n;
    nxt_oe[1]  = ~fdc_density_sel_0;
    nxt_oe[2]  = ~fdc_head_side0;
    nxt_oe[3]  = ~fdc_write_en_n;
    nxt_oe[4]  = ~fdc_write_data_n;
    nxt_oe[5]  = ~fdc_step_n;
    nxt_oe[6]  = ~fdc_dir_out;
    nxt_oe[7]  = ~fdc_motor_on_b_n;
    nxt_oe[8]  = ~fdc_motor_on_a_n;
    nxt_oe[9]  = ~fdc_drive_select_a_n;
    nxt_oe[10] = ~fdc_drive_select_b_n;
  end
  always_ff @(posedge clk) begin
    if (srst) oe_ff <= 11'h000;
    else      oe_ff <= nxt_oe;
  end
  assign nxt_out = 8'h00;
  always_ff @(posedge clk) begin
    if (srst) out_ff <= 8'h00;
    else      out_ff <= nxt_out;
  end
  assign printer_data_bit7_out = out_ff[0];
  assign printer_data_bit7_oe  = oe_ff[0];
  assign density_sel_0_oe      = oe_ff[1];
  assign head_oe               = oe_ff[2];
  assign head_out              = out_ff[1];
  assign write_en_oe           = oe_ff[3];
  assign write_serial_out_oe   = oe_ff[4];
  assign step_oe               = oe_ff[5];
  assign dir_oe                = oe_ff[6];
  assign motor_on_b_oe         = oe_ff[7];
  assign motor_on_a_oe         = oe_ff[8];
  assign drive_select_a_oe     = oe_ff[9];
  assign drive_select_b_oe     = oe_ff[10];

  // shared output pins: only the selected function drives
  always_comb begin
    nxt_mux_out = 4'h0;
    nxt_mux_oe  = 4'h0;
    unique case (den1_sel)
      fpfs_pkg::DEN1_DENSITY: begin
        nxt_mux_out[0] = 1'b0;
        nxt_mux_oe[0]  = ~fdc_density_sel_1;
      end
      fpfs_pkg::DEN1_GPIO: begin
        nxt_mux_out[0] = gpio1_dout[0];
        nxt_mux_oe[0]  = gpio1_oe[0];
      end
      fpfs_pkg::DEN1_KBC: begin
        nxt_mux_out[0] = kbc_port_line_twelve_out;
        nxt_mux_oe[0]  = kbc_port_line_twelve_oe;
      end
      fpfs_pkg::DEN1_SCI: begin
        nxt_mux_out[0] = 1'b0;
        nxt_mux_oe[0]  = ~system_ctl_irq_n;
      end
    endcase
    if (addr_line20_gate_gpio) begin
      nxt_mux_out[1] = gpio1_dout[1];
      nxt_mux_oe[1]  = gpio1_oe[1];
    end else begin
      nxt_mux_out[1] = addr_line20_gate;
      nxt_mux_oe[1]  = 1'b1;
    end
    if (kbd_reset_out_gpio) begin
      nxt_mux_out[2] = wdog_on_gpio12 ? wdog_timeout_out : gpio1_dout[2];
      nxt_mux_oe[2]  = wdog_on_gpio12 | gpio1_oe[2];
    end else begin
      nxt_mux_out[2] = kbd_reset_out;
      nxt_mux_oe[2]  = 1'b1;
    end
    nxt_mux_out[3] = gpio1_dout[3];
    nxt_mux_oe[3]  = kinh_gpio & gpio1_oe[3];
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      mux_out_ff <= 4'h0;
      mux_oe_ff  <= 4'h0;
    end else begin
      mux_out_ff <= nxt_mux_out;
      mux_oe_ff  <= nxt_mux_oe;
    end
  end
  assign density_sel_1_out = mux_out_ff[0];
  assign density_sel_1_oe  = mux_oe_ff[0];
  assign a20_pin_out       = mux_out_ff[1];
  assign a20_pin_oe        = mux_oe_ff[1];
  assign kbd_reset_out_pin_out     = mux_out_ff[2];
  assign kbd_reset_out_pin_oe      = mux_oe_ff[2];
  assign kinh_pin_out      = mux_out_ff[3];
  assign kinh_pin_oe       = mux_oe_ff[3];

  // checks
  AST_EXT_DSA: assert property (@(posedge clk) disable iff (srst)
    !ext_two_drive_mode |=> !printer_data_bit7_oe)
    else $error("ext drive select driven outside two-drive mode");
  AST_STEP_PULSE: assert property (@(posedge clk) disable iff (srst)
    $fell(fdc_step_n) |=> step_oe)
    else $error("step pulse not driven");
  AST_DIR: assert property (@(posedge clk) disable iff (srst)
    fdc_dir_out |=> !dir_oe)
    else $error("outward direction pulled low");
  AST_HEAD: assert property (@(posedge clk) disable iff (srst)
    !fdc_head_side0 |=> head_oe)
    else $error("side 1 not selected");
  AST_MOTOR_A: assert property (@(posedge clk) disable iff (srst)
    motor_on_a_oe == !$past(fdc_motor_on_a_n))
    else $error("motor a output wrong");
  AST_MOTOR_B: assert property (@(posedge clk) disable iff (srst)
    motor_on_b_oe == !$past(fdc_motor_on_b_n))
    else $error("motor b output wrong");
  AST_SCI: assert property (@(posedge clk) disable iff (srst)
    den1_sel != fpfs_pkg::DEN1_SCI ##1 den1_sel != fpfs_pkg::DEN1_SCI
    |-> !(density_sel_1_oe && $past(system_ctl_irq_n) && $past(fdc_density_sel_1)
          && $past(den1_sel) == fpfs_pkg::DEN1_DENSITY))
    else $error("density pin driven while released");
  AST_KINH: assert property (@(posedge clk) disable iff (srst)
    !kinh_gpio |=> !kinh_pin_oe)
    else $error("inhibit pin driven in input mode");
  AST_WRITE: assert property (@(posedge clk) disable iff (srst)
    !fdc_write_data_n |=> write_serial_out_oe)
    else $error("write data not driven");

  // step request falls, then rises one cycle later
  sequence fpfs_step_start;
    $fell(fdc_step_n);
  endsequence
  sequence fpfs_step_stop;
    $rose(fdc_step_n);
  endsequence
  AST_STEP_ONE: assert property (@(posedge clk) disable iff (srst)
    fpfs_step_start ##1 fpfs_step_stop |=> !step_oe)
    else $error("step pulse not released");
  AST_DIR_IN: assert property (@(posedge clk) disable iff (srst)
    !fdc_dir_out |=> dir_oe)
    else $error("inward direction not pulled low");
  AST_DEN0: assert property (@(posedge clk) disable iff (srst)
    density_sel_0_oe == !$past(fdc_density_sel_0))
    else $error("density bit 0 output wrong");
  AST_WE: assert property (@(posedge clk) disable iff (srst)
    !fdc_write_en_n |=> write_en_oe)
    else $error("write enable not driven");
  AST_DSA: assert property (@(posedge clk) disable iff (srst)
    drive_select_a_oe == !$past(fdc_drive_select_a_n))
    else $error("drive select a output wrong");
  AST_DSB: assert property (@(posedge clk) disable iff (srst)
    drive_select_b_oe == !$past(fdc_drive_select_b_n))
    else $error("drive select b output wrong");
  AST_EXT_ON: assert property (@(posedge clk) disable iff (srst)
    ext_two_drive_mode && !fdc_ext_drive_a_select_n |=> printer_data_bit7_oe)
    else $error("ext drive select not driven");
  AST_DEN1_DENS: assert property (@(posedge clk) disable iff (srst)
    $past(den1_sel) == fpfs_pkg::DEN1_DENSITY |-> density_sel_1_oe == !$past(fdc_density_sel_1))
    else $error("density bit 1 output wrong");
  AST_DEN1_GPIO: assert property (@(posedge clk) disable iff (srst)
    $past(den1_sel) == fpfs_pkg::DEN1_GPIO |-> density_sel_1_oe == $past(gpio1_oe[0]))
    else $error("gpio enable not on density pin");
  AST_DEN1_KBC: assert property (@(posedge clk) disable iff (srst)
    $past(den1_sel) == fpfs_pkg::DEN1_KBC |-> density_sel_1_oe == $past(kbc_port_line_twelve_oe))
    else $error("kbc enable not on density pin");
  AST_DEN1_SCI: assert property (@(posedge clk) disable iff (srst)
    $past(den1_sel) == fpfs_pkg::DEN1_SCI |-> density_sel_1_oe == !$past(system_ctl_irq_n))
    else $error("system interrupt not on density pin");
  AST_DEN1_OD: assert property (@(posedge clk) disable iff (srst)
    density_sel_1_oe && $past(den1_sel) != fpfs_pkg::DEN1_GPIO
    && $past(den1_sel) != fpfs_pkg::DEN1_KBC |-> !density_sel_1_out)
    else $error("open-drain density pin driven high");
  AST_A20: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$past(addr_line20_gate_gpio)
    |-> a20_pin_oe && a20_pin_out == $past(addr_line20_gate))
    else $error("gate a20 not on its pin");
  AST_A20_GPIO: assert property (@(posedge clk) disable iff (srst)
    $past(addr_line20_gate_gpio) |-> a20_pin_oe == $past(gpio1_oe[1]))
    else $error("gpio bit 1 enable not on a20 pin");
  AST_KBD_RESET_OUT: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && !$past(kbd_reset_out_gpio)
    |-> kbd_reset_out_pin_oe && kbd_reset_out_pin_out == $past(kbd_reset_out))
    else $error("keyboard reset not on its pin");
  AST_WDOG: assert property (@(posedge clk) disable iff (srst)
    !$past(srst) && $past(kbd_reset_out_gpio && wdog_on_gpio12)
    |-> kbd_reset_out_pin_oe && kbd_reset_out_pin_out == $past(wdog_timeout_out))
    else $error("watchdog not on reset pin");
  AST_KINH_GPIO: assert property (@(posedge clk) disable iff (srst)
    $past(kinh_gpio) |-> kinh_pin_oe == $past(gpio1_oe[3]))
    else $error("gpio bit 3 enable not on inhibit pin");
  AST_IRQ1: assert property (@(posedge clk) disable iff (srst)
    alt_irq_input_1 |-> den1_sel == fpfs_pkg::DEN1_GPIO)
    else $error("irq input 1 active outside gpio mode");
  AST_IRQ2: assert property (@(posedge clk) disable iff (srst)
    alt_irq_input_2 |-> addr_line20_gate_gpio)
    else $error("irq input 2 active outside gpio mode");
  AST_KINH_IN: assert property (@(posedge clk) disable iff (srst)
    kinh_gpio |-> kbd_inhibit_in)
    else $error("inhibit input not idle in gpio mode");
  AST_KBC_IN: assert property (@(posedge clk) disable iff (srst)
    den1_sel != fpfs_pkg::DEN1_KBC |-> kbc_port_line_twelve_in)
    else $error("kbc line fed while unselected");
  AST_MEDIA: assert property (@(posedge clk) disable iff (srst)
    media_changed == !$past(mc1_ff))
    else $error("media change status wrong");
  AST_RDATA: assert property (@(posedge clk) disable iff (srst)
    read_data == !$past(s1_ff[0]))
    else $error("read data status wrong");
endmodule : fpfs_pins
`default_nettype wire

// File: test/fpfs_drive_model.sv
// Purpose: floppy drive model facing the pin block
// Assumes: an open-drain oe high pulls its pin low
// Notes: pads change 1 ns after the falling clock edge
`timescale 1ns/100ps
`default_nettype none
module fpfs_drive_model (
  input  wire logic clk,
  input  wire logic step_oe,
  input  wire logic dir_oe,
  input  wire logic motor_on_a_oe,
  input  wire logic wp_req,
  output logic      media_changed_in,
  output logic      read_data_in,
  output logic      write_protect_in,
  output logic      track_zero_in,
  output logic      index_in
);
  int   track = 0;
  int   rot = 0;
  logic step_d = 1'b0;
  initial begin
    media_changed_in = 1'b0;
    {read_data_in, write_protect_in, track_zero_in, index_in} = 4'hF;
  end
  always @(negedge clk) begin
    #1;
    if (step_oe && !step_d) begin
      media_changed_in = 1'b1;
      if (dir_oe)
        track = track + 1;
      else if (track > 0)
        track = track - 1;
    end
    step_d = step_oe;
    rot = motor_on_a_oe ? (rot + 1) % 20 : rot;
    index_in = !(motor_on_a_oe && rot < 2);
    track_zero_in = (track != 0);
    write_protect_in = !wp_req;
    read_data_in = motor_on_a_oe ? rot[0] : 1'b1;
  end
endmodule : fpfs_drive_model
`default_nettype wire

// File: test/tb_fpfs_pins.sv
// Purpose: self-checking bench for the floppy pin and function select block
// Assumes: inputs change on the falling clock edge
// Notes: a note queue pairs each driven cycle with its checks
`timescale 1ns/100ps
`default_nettype none
module tb_fpfs_pins;
  typedef struct {
    logic [14:0] oe;
    logic [6:0]  ou;
    logic [12:0] st;
    logic        pu;
    bit          ok;
  } fpfs_note_t;
  fpfs_note_t  notes[$];
  fpfs_note_t  e, n;
  logic        clk, srst, two_drv, wp_req, wdog_sel, kbc_o, kbc_oe, sci_n, a20g, kbr, wdt;
  logic [7:0]  cfg_a, cfg_b, fopt;
  logic [11:0] fdc;
  logic [3:0]  g_oe, g_do, pad, pp;
  logic [14:0] oe, op;
  logic [6:0]  ou, uop, msk;
  logic [12:0] st;
  logic        puo, mc, rd, wp, tz, ix;
  logic [31:0] seed = 32'h0BAECF2B;
  wire  [3:0]  lv;
  int          k, cyc, bad_count, checked;
  assign lv = {oe[12] ? ou[3] : pad[3], oe[2] ? ou[2] : pad[2],
               oe[1] ? ou[1] : pad[1], oe[0] ? ou[0] : pad[0]};
  fpfs_pins fpfs_pins_i (.clk(clk), .srst(srst), .pin_select_cfg_a(cfg_a),
    .pin_select_cfg_b(cfg_b), .floppy_option_cfg(fopt), .ext_two_drive_mode(two_drv),
    .fdc_ext_drive_a_select_n(fdc[11]), .fdc_density_sel_0(fdc[10]),
    .fdc_density_sel_1(fdc[9]), .fdc_head_side0(fdc[8]), .fdc_write_en_n(fdc[7]),
    .fdc_write_data_n(fdc[6]), .fdc_step_n(fdc[5]), .fdc_dir_out(fdc[4]),
    .fdc_motor_on_a_n(fdc[3]), .fdc_motor_on_b_n(fdc[2]),
    .fdc_drive_select_a_n(fdc[1]), .fdc_drive_select_b_n(fdc[0]), .gpio1_out(1'b0),
    .gpio1_oe(g_oe), .gpio1_dout(g_do), .kbc_port_line_twelve_out(kbc_o),
    .kbc_port_line_twelve_oe(kbc_oe), .system_ctl_irq_n(sci_n), .addr_line20_gate(a20g),
    .kbd_reset_out(kbr), .wdog_timeout_out(wdt), .wdog_on_gpio12(wdog_sel),
    .gpio1_din(st[7:4]), .alt_irq_input_1(st[3]), .alt_irq_input_2(st[2]),
    .kbc_port_line_twelve_in(st[1]), .kbd_inhibit_in(st[0]), .media_changed(st[12]),
    .read_data(st[11]), .write_protected(st[10]), .track_zero(st[9]),
    .index_mark(st[8]), .input_pullup_off(puo), .printer_data_bit7_in(!oe[14]),
    .printer_data_bit7_out(ou[5]), .printer_data_bit7_oe(oe[14]),
    .density_sel_0_oe(oe[13]), .density_sel_1_in(lv[3]), .density_sel_1_out(ou[3]),
    .density_sel_1_oe(oe[12]), .head_oe(oe[11]), .write_en_oe(oe[10]),
    .write_serial_out_oe(oe[9]), .step_oe(oe[8]), .dir_oe(oe[7]), .motor_on_b_oe(oe[5]),
    .motor_on_a_oe(oe[6]), .drive_select_a_oe(oe[4]), .drive_select_b_oe(oe[3]),
    .media_changed_in(mc), .read_data_in(rd), .write_protect_in(wp),
    .track_zero_in(tz), .index_in(ix), .a20_pin_in(lv[2]), .a20_pin_out(ou[2]),
    .a20_pin_oe(oe[2]), .kbd_reset_out_pin_in(lv[1]), .kbd_reset_out_pin_out(ou[1]), .kbd_reset_out_pin_oe(oe[1]),
    .kinh_pin_in(lv[0]), .kinh_pin_out(ou[0]), .kinh_pin_oe(oe[0]), .head_out(ou[4]),
    .od_low(ou[6]));
  fpfs_drive_model fpfs_drive_model_i (.clk(clk), .step_oe(oe[8]), .dir_oe(oe[7]),
    .motor_on_a_oe(oe[6]), .wp_req(wp_req), .media_changed_in(mc), .read_data_in(rd),
    .write_protect_in(wp), .track_zero_in(tz), .index_in(ix));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs
  task automatic chk(input string nm, input logic [14:0] ex, input logic [14:0] ac);
    checked++;
    if (ac !== ex) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, ac);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    srst = 1'b1;
    {two_drv, wp_req, wdog_sel, kbc_o, kbc_oe, sci_n, a20g, kbr, wdt} = 9'h000;
    {cfg_a, cfg_b, fopt} = 24'h000000;
    fdc = 12'hFFF;
    {g_oe, g_do, pad} = 12'h000;
    op = 15'h0000;
    uop = 7'h00;
    repeat (12) @(negedge clk);
    srst = 1'b0;
    for (k = 0; k < 2000; k++) begin
      @(negedge clk);
      pp = {op[12] ? uop[3] : pad[3], op[2] ? uop[2] : pad[2],
            op[1] ? uop[1] : pad[1], op[0] ? uop[0] : pad[0]};
      e.st[12:8] = ~{mc, rd, wp, tz, ix};
      op = oe;
      uop = ou;
      seed = xs(seed);
      if (k % 16 == 0) begin
        cfg_a = {seed[7:2], k[5:4]};
        {cfg_b, fopt, two_drv, wp_req, wdog_sel} = seed[26:8];
      end
      seed = xs(seed);
      {fdc, g_oe, g_do, pad, kbc_o, kbc_oe, sci_n, a20g, kbr, wdt} = seed[29:0];
      e.st[7:4] = {cfg_b[0] & pp[0], cfg_a[7] & pp[1], cfg_a[6] & pp[2],
                   (cfg_a[1:0] == fpfs_pkg::DEN1_GPIO) & pp[3]};
      e.st[3:0] = {e.st[4], e.st[5], (cfg_a[1:0] == fpfs_pkg::DEN1_KBC) ? pp[3] : 1'b1,
                   cfg_b[0] | pp[0]};
      e.oe = {~fdc, 3'b000};
      e.oe[14] = two_drv & ~fdc[11];
      e.ou[6:4] = 3'b000;
      case (cfg_a[fpfs_pkg::DEN1_SEL_LSB +: 2])
        fpfs_pkg::DEN1_DENSITY: {e.oe[12], e.ou[3]} = {~fdc[9], 1'b0};
        fpfs_pkg::DEN1_GPIO:    {e.oe[12], e.ou[3]} = {g_oe[0], g_do[0]};
        fpfs_pkg::DEN1_KBC:     {e.oe[12], e.ou[3]} = {kbc_oe, kbc_o};
        default:                {e.oe[12], e.ou[3]} = {~sci_n, 1'b0};
      endcase
      e.oe[2] = cfg_a[6] ? g_oe[1] : 1'b1;
      e.ou[2] = cfg_a[6] ? g_do[1] : a20g;
      e.oe[1] = !cfg_a[7] | wdog_sel | g_oe[2];
      e.ou[1] = !cfg_a[7] ? kbr : (wdog_sel ? wdt : g_do[2]);
      e.oe[0] = cfg_b[0] & g_oe[3];
      e.ou[0] = g_do[3];
      e.pu = fopt[7];
      e.ok = (k % 16) >= 3;
      notes.push_back(e);
    end
    repeat (2) @(negedge clk);
    report_and_stop();
  end
  initial forever begin
    @(posedge clk);
    #1;
    if (notes.size() > 0) begin
      n = notes.pop_front();
      msk = {3'h7, n.oe[12], n.oe[2:0]};
      chk("oe", n.oe, oe);
      chk("out", 15'(n.ou & msk), 15'(ou & msk));
      chk("pullup", 15'(n.pu), 15'(puo));
      if (n.ok)
        chk("status", 15'(n.st), 15'(st));
    end
  end
endmodule : tb_fpfs_pins
`default_nettype wire
